/* File: src/acmd_top.sv */
`timescale 1ns/1ns
`default_nettype none
// What this block does
// RULE_01 - All bits clear: single-ended, binary output
// RULE_02 - Only bipolar: differential pair, two's complement
// RULE_03 - Pseudo bit only: differential pair, binary
// RULE_04 - Pseudo and bipolar: pseudo wins, binary
// RULE_05 - Common bit: channel against shared reference
// RULE_06 - Odd channel decodes like even channel
// RULE_07 - Host writes pseudo/common word, code 10001
// RULE_08 - Host writes bipolar word, code 10010
// RULE_09 - Every pair decodes with its own bits
module acmd_top (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic cfg_wr_i, // One-cycle strobe of a config word
  input wire logic [15:0] cfg_word_i, // Config word from serial port
  input wire logic [3:0] channel_select_code_i, // Selected channel
  input wire logic [15:0] scan_include_i, // Scan bits per channel
  output acmd_pkg::acmd_mode_e mode_o, // Registered input mode
  output logic twos_comp_o, // Registered coding, 1 = two's complement
  output logic [3:0] pos_ch_o, // Registered positive input channel
  output logic [3:0] neg_ch_o, // Registered negative input channel
  output logic [7:0] pseudo_diff_o, // Current pseudo-differential bits
  output logic [7:0] bipolar_o, // Current bipolar bits
  output logic common_ref_enable_o, // Current common reference bit
  output logic [15:0] scan_twos_comp_o // Coding per scanned channel
);
  import acmd_pkg::*;

  acmd_cfg_if cfg ();

  logic [7:0] pseudo_q; // Pseudo-differential pair bits
  logic [7:0] bipolar_q; // Bipolar pair bits
  logic common_q; // Shared reference bit
  logic [4:0] sel; // Word select field
  // Decoder results, one cycle ahead of the outputs
  acmd_mode_e mode_d; // Next input mode
  logic twos_d; // Next coding
  logic [3:0] pos_d; // Next positive channel
  logic [3:0] neg_d; // Next negative channel
  logic [15:0] scan_twos_d; // Next coding per scanned channel

  // Select field sits in the top five bits of the word
  assign sel = cfg_word_i[15:ACMD_SEL_LSB];

  // Pseudo word, bit 10 is pair 0/1 down to bit 3 for pair 14/15
  // RULE_07 pseudo word capture
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pseudo_q <= ACMD_PAIRS_RST;
      common_q <= ACMD_COMMON_RST;
    end else if (cfg_wr_i && sel == ACMD_SEL_UNI) begin
      // Whole word loads; no partial update of single pairs
      pseudo_q <= cfg_word_i[ACMD_PAIR01_BIT -: 8];
      common_q <= cfg_word_i[ACMD_COMMON_BIT];
    end
  end

  // Bipolar word; other select codes are ignored here
  // RULE_08 bipolar word capture
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bipolar_q <= ACMD_PAIRS_RST;
    end else if (cfg_wr_i && sel == ACMD_SEL_BIP) begin
      // Only a matching select code loads the word
      bipolar_q <= cfg_word_i[ACMD_PAIR01_BIT -: 8];
    end
  end

  // Word bit order runs pair 0 at the top; flip to index order
  genvar g;
  generate
    for (g = 0; g < ACMD_NUM_PAIRS; g++) begin : g_pair
      assign cfg.pseudo_diff[g] = pseudo_q[ACMD_NUM_PAIRS - 1 - g];
      assign cfg.bipolar[g] = bipolar_q[ACMD_NUM_PAIRS - 1 - g];
    end
    // Coding of each channel as a scan would convert it
    // RULE_09 per pair decode
    for (g = 0; g < ACMD_NUM_CH; g++) begin : g_scan
      assign scan_twos_d[g] = scan_include_i[g] && !common_q &&
        !cfg.pseudo_diff[g / 2] && cfg.bipolar[g / 2];
    end
  endgenerate
  assign cfg.common_ref_enable = common_q;

  // RULE_01 decode, also RULE_02 to RULE_06
  acmd_decode u_dec (
    .cfg(cfg),
    .channel_select_code_i(channel_select_code_i),
    .mode_o(mode_d),
    .twos_comp_o(twos_d),
    .pos_ch_o(pos_d),
    .neg_ch_o(neg_d)
  );

  // Register results so outputs are glitch free
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      // Idle as single-ended channel 0
      mode_o <= ACMD_SINGLE;
      twos_comp_o <= 1'b0;
      pos_ch_o <= 4'h0;
      neg_ch_o <= 4'h0;
      scan_twos_comp_o <= 16'h0000;
    end else begin
      // Follow the decoder one cycle late
      mode_o <= mode_d;
      twos_comp_o <= twos_d;
      pos_ch_o <= pos_d;
      neg_ch_o <= neg_d;
      scan_twos_comp_o <= scan_twos_d;
    end
  end

  // Register bits shown as written, pair 0/1 at the top
  assign pseudo_diff_o = pseudo_q;
  assign bipolar_o = bipolar_q;
  assign common_ref_enable_o = common_q;

  // Assertions
  // RULE_02 two's complement only when bipolar alone
  property p_twos;
    @(posedge mclk_i) disable iff (reset_i)
    // Coding was fixed by the previous cycle's common bit
    twos_comp_o |-> mode_o == ACMD_DIFF && !$past(common_q);
  endproperty
  a_twos: assert property (p_twos) else $error("twos without diff"); // RULE_02
  // RULE_05 common mode routes to channel 15
  property p_common;
    @(posedge mclk_i) disable iff (reset_i)
    common_q && $stable(common_q) |=> mode_o == ACMD_PSEUDO_COMMON &&
      neg_ch_o == ACMD_COMMON_CH && !twos_comp_o;
  endproperty
  a_common: assert property (p_common) else $error("common wrong"); // RULE_05
  // RULE_04 pseudo wins over bipolar
  property p_prec;
    @(posedge mclk_i) disable iff (reset_i)
    !common_q && cfg.pseudo_diff[channel_select_code_i[3:1]] |=>
      !twos_comp_o && mode_o == ACMD_DIFF;
  endproperty
  a_prec: assert property (p_prec) else $error("precedence lost"); // RULE_04
  // RULE_01 all clear gives single ended
  property p_single;
    @(posedge mclk_i) disable iff (reset_i)
    !common_q && !cfg.pseudo_diff[channel_select_code_i[3:1]] &&
      !cfg.bipolar[channel_select_code_i[3:1]] |=>
      mode_o == ACMD_SINGLE && pos_ch_o == $past(channel_select_code_i);
  endproperty
  a_single: assert property (p_single) else $error("single wrong"); // RULE_01
  // RULE_03 differential pair uses even then odd
  property p_pair;
    @(posedge mclk_i) disable iff (reset_i)
    mode_o == ACMD_DIFF |-> !pos_ch_o[0] && neg_ch_o == (pos_ch_o | 4'h1);
  endproperty
  a_pair: assert property (p_pair) else $error("pair order wrong"); // RULE_03
  // RULE_06 odd channel decodes to same pair
  property p_odd;
    @(posedge mclk_i) disable iff (reset_i)
    channel_select_code_i[0] && !common_q &&
      cfg.bipolar[channel_select_code_i[3:1]] |=> pos_ch_o[0] == 1'b0;
  endproperty
  a_odd: assert property (p_odd) else $error("odd channel wrong"); // RULE_06
  // RULE_07 pseudo word lands next cycle
  property p_uni_wr;
    @(posedge mclk_i) disable iff (reset_i)
    cfg_wr_i && sel == ACMD_SEL_UNI |=>
      pseudo_q == $past(cfg_word_i[10:3]) && bipolar_q == $past(bipolar_q);
  endproperty
  a_uni_wr: assert property (p_uni_wr) else $error("uni write"); // RULE_07
  // RULE_08 bipolar word lands next cycle
  property p_bip_wr;
    @(posedge mclk_i) disable iff (reset_i)
    cfg_wr_i && sel == ACMD_SEL_BIP |=>
      bipolar_q == $past(cfg_word_i[10:3]) && pseudo_q == $past(pseudo_q);
  endproperty
  a_bip_wr: assert property (p_bip_wr) else $error("bip write"); // RULE_08
  // RULE_09 scan coding follows pair bits
  property p_scan;
    @(posedge mclk_i) disable iff (reset_i)
    scan_include_i[15] && !common_q && !cfg.pseudo_diff[7] &&
      cfg.bipolar[7] |=> scan_twos_comp_o[15];
  endproperty
  a_scan: assert property (p_scan) else $error("scan coding wrong"); // RULE_09
  // RULE_02 bipolar alone gives two's complement pair
  property p_bip_only;
    @(posedge mclk_i) disable iff (reset_i)
    !common_q && !cfg.pseudo_diff[channel_select_code_i[3:1]] &&
      cfg.bipolar[channel_select_code_i[3:1]] |=>
      twos_comp_o && mode_o == ACMD_DIFF;
  endproperty
  a_bip_only: assert property (p_bip_only) else $error("bip wrong"); // RULE_02
  // RULE_06 odd channel with pseudo bit joins its pair
  property p_odd_uni;
    @(posedge mclk_i) disable iff (reset_i)
    channel_select_code_i[0] && !common_q &&
      cfg.pseudo_diff[channel_select_code_i[3:1]] |=>
      mode_o == ACMD_DIFF && !twos_comp_o &&
      neg_ch_o == $past(channel_select_code_i);
  endproperty
  a_odd_uni: assert property (p_odd_uni) else $error("odd pair"); // RULE_06
  // RULE_08 pair bits and outputs clear out of reset
  property p_rst;
    @(posedge mclk_i)
    $past(reset_i) && !reset_i |-> pseudo_q == ACMD_PAIRS_RST &&
      bipolar_q == ACMD_PAIRS_RST && common_q == ACMD_COMMON_RST &&
      mode_o == ACMD_SINGLE && !twos_comp_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset wrong"); // RULE_08
  // RULE_07 unknown select codes leave settings alone
  property p_refuse;
    @(posedge mclk_i) disable iff (reset_i)
    cfg_wr_i && sel != ACMD_SEL_UNI && sel != ACMD_SEL_BIP |=>
      $stable(pseudo_q) && $stable(bipolar_q) && $stable(common_q);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused"); // RULE_07
  // RULE_09 channels left out of a scan report binary
  property p_scan_off;
    @(posedge mclk_i) disable iff (reset_i)
    1'b1 |=> (scan_twos_comp_o & ~$past(scan_include_i)) == 16'h0000;
  endproperty
  a_scan_off: assert property (p_scan_off) else $error("scan off"); // RULE_09

  // Main scenarios worth seeing at least once
  c_bip: cover property (@(posedge mclk_i) twos_comp_o);
  c_com: cover property (@(posedge mclk_i) mode_o == ACMD_PSEUDO_COMMON);
  c_prec: cover property (@(posedge mclk_i)
    mode_o == ACMD_DIFF && !twos_comp_o);
  c_odd_single: cover property (@(posedge mclk_i)
    mode_o == ACMD_SINGLE && pos_ch_o[0]);
  c_scan: cover property (@(posedge mclk_i) |scan_twos_comp_o);
endmodule // acmd_top
`default_nettype wire

/* File: src/acmd_pkg.sv */
package acmd_pkg;
  // Channel count and pair count
  localparam int ACMD_NUM_CH = 16;
  localparam int ACMD_NUM_PAIRS = 8;
  // Configuration word select codes, top five bits
  localparam logic [4:0] ACMD_SEL_UNI = 5'h11;
  localparam logic [4:0] ACMD_SEL_BIP = 5'h12;
  // Field positions inside a configuration word
  localparam int ACMD_SEL_LSB = 11;
  localparam int ACMD_PAIR01_BIT = 10;
  localparam int ACMD_COMMON_BIT = 2;
  // Reset values of the pair and common bits
  localparam logic [7:0] ACMD_PAIRS_RST = 8'h00;
  localparam logic ACMD_COMMON_RST = 1'b0;
  // Shared reference input channel number
  localparam logic [3:0] ACMD_COMMON_CH = 4'hf;

  // Input configuration modes
  typedef enum logic [1:0] {
    ACMD_SINGLE = 2'b00,
    ACMD_PSEUDO_COMMON = 2'b01,
    ACMD_DIFF = 2'b10
  } acmd_mode_e;
endpackage

/* File: src/acmd_cfg_if.sv */
`timescale 1ns/1ns
`default_nettype none
// Decoded settings passed from the register half to the decoder
interface acmd_cfg_if;
  logic [7:0] pseudo_diff; // Per-pair pseudo-differential bits
  logic [7:0] bipolar; // Per-pair bipolar bits
  logic common_ref_enable; // Shared reference mode
  modport regs (output pseudo_diff, output bipolar, output common_ref_enable);
  modport dec (input pseudo_diff, input bipolar, input common_ref_enable);
endinterface
`default_nettype wire

/* File: src/acmd_decode.sv */
`timescale 1ns/1ns
`default_nettype none
// Combinational per-channel mode decode
module acmd_decode (
  acmd_cfg_if.dec cfg,
  input wire logic [3:0] channel_select_code_i,
  output acmd_pkg::acmd_mode_e mode_o,
  output logic twos_comp_o,
  output logic [3:0] pos_ch_o,
  output logic [3:0] neg_ch_o
);
  import acmd_pkg::*;

  logic [2:0] pair; // Pair index of the chosen channel
  assign pair = channel_select_code_i[3:1];

  // Common mode wins over everything, then pseudo bit over bipolar
  always_comb begin
    mode_o = ACMD_SINGLE;
    twos_comp_o = 1'b0;
    pos_ch_o = channel_select_code_i;
    neg_ch_o = channel_select_code_i;
    if (cfg.common_ref_enable) begin
      // Common reference, pair bits ignored
      mode_o = ACMD_PSEUDO_COMMON;
      neg_ch_o = ACMD_COMMON_CH;
    end else if (cfg.pseudo_diff[pair]) begin
      // Unipolar setting takes precedence
      mode_o = ACMD_DIFF;
      pos_ch_o = {pair, 1'b0};
      neg_ch_o = {pair, 1'b1};
    end else if (cfg.bipolar[pair]) begin
      // Bipolar fully differential
      mode_o = ACMD_DIFF;
      twos_comp_o = 1'b1;
      pos_ch_o = {pair, 1'b0};
      neg_ch_o = {pair, 1'b1};
    end
  end
endmodule // acmd_decode
`default_nettype wire

/* File: dv/acmd_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Host side: writes configuration words over the serial port
module acmd_host_model (
  input wire logic mclk_i,
  output logic cfg_wr_o,
  output logic [15:0] cfg_word_o
);
  import acmd_pkg::*;
  // Idle bus at start
  initial begin
    cfg_wr_o = 1'h0;
    cfg_word_o = 16'h0000;
  end
  // Two words back to back; released bus shows the inverse
  // so a stale word can never look valid
  task automatic wr(input logic [15:0] a, input logic [15:0] b);
    @(posedge mclk_i);
    #1;
    cfg_wr_o = 1'h1;
    cfg_word_o = a;
    @(posedge mclk_i);
    #1;
    cfg_word_o = b;
    @(posedge mclk_i);
    #1;
    cfg_wr_o = 1'h0;
    cfg_word_o = ~b;
  endtask
  function automatic logic [15:0] uni(input logic [7:0] u, input logic c);
    return {ACMD_SEL_UNI, u, c, 2'h0};
  endfunction
  function automatic logic [15:0] bip(input logic [7:0] b);
    return {ACMD_SEL_BIP, b, 3'h0};
  endfunction
endmodule // acmd_host_model
`default_nettype wire

/* File: dv/acmd_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// Self-checking bench for the channel mode decode
module acmd_top_tb_top;
  import acmd_pkg::*;
  // Settings, channel, expected mode and coding
  typedef struct packed {
    logic [7:0] u;
    logic [7:0] b;
    logic c;
    logic [3:0] ch;
    logic [1:0] m;
    logic t;
  } acmd_row_s;
  logic mclk_i = 1'h0;
  logic reset_i = 1'h1;
  logic cfg_wr;
  logic [15:0] cfg_word;
  logic [3:0] sel = 4'h0;
  logic [15:0] scan = 16'h0000;
  acmd_mode_e mode_o;
  logic twos_comp_o;
  logic [3:0] pos_ch_o;
  logic [3:0] neg_ch_o;
  logic [7:0] pseudo_diff_o;
  logic [7:0] bipolar_o;
  logic common_ref_enable_o;
  logic [15:0] scan_twos_comp_o;
  int errors = 0;
  int checked = 0;
  acmd_row_s r;
  acmd_row_s rows [10] = '{
    '{8'h00, 8'h00, 1'h0, 4'h0, 2'h0, 1'h0},
    '{8'h00, 8'h80, 1'h0, 4'h0, 2'h2, 1'h1},
    '{8'h80, 8'h00, 1'h0, 4'h0, 2'h2, 1'h0},
    '{8'h80, 8'h80, 1'h0, 4'h0, 2'h2, 1'h0},
    '{8'h80, 8'h80, 1'h1, 4'h0, 2'h1, 1'h0},
    '{8'h00, 8'h80, 1'h0, 4'h1, 2'h2, 1'h1},
    '{8'h00, 8'h00, 1'h0, 4'h1, 2'h0, 1'h0},
    '{8'h00, 8'h01, 1'h0, 4'he, 2'h2, 1'h1},
    '{8'h01, 8'h00, 1'h0, 4'hf, 2'h2, 1'h0},
    '{8'hbf, 8'h80, 1'h0, 4'h2, 2'h0, 1'h0}
  };
  // 250 MHz clock
  always #2 mclk_i = ~mclk_i;
  acmd_host_model acmd_host_model_i (.mclk_i(mclk_i), .cfg_wr_o(cfg_wr),
    .cfg_word_o(cfg_word));
  acmd_top acmd_top_i (.mclk_i(mclk_i), .reset_i(reset_i),
    .cfg_wr_i(cfg_wr), .cfg_word_i(cfg_word), .channel_select_code_i(sel),
    .scan_include_i(scan), .mode_o(mode_o), .twos_comp_o(twos_comp_o),
    .pos_ch_o(pos_ch_o), .neg_ch_o(neg_ch_o), .pseudo_diff_o(pseudo_diff_o),
    .bipolar_o(bipolar_o), .common_ref_enable_o(common_ref_enable_o),
    .scan_twos_comp_o(scan_twos_comp_o));
  // Expected input pair: single, against channel 15, or pair
  function automatic logic [7:0] chans(input acmd_row_s x);
    case (x.m)
      2'h1: return {x.ch, ACMD_COMMON_CH};
      2'h2: return {x.ch[3:1], 1'h0, x.ch[3:1], 1'h1};
      default: return {x.ch, x.ch};
    endcase
  endfunction
  // Compare and count
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Counts, verdict, end of run
  task automatic close_out();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Let outputs settle two edges after the last write
  task automatic settle();
    repeat (2) @(posedge mclk_i);
    #1;
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    reset_i = 1'h0;
    chk("rst", {pseudo_diff_o, bipolar_o}, 16'h0000);
    chk("rmode", 16'(mode_o), 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      sel = r.ch;
      acmd_host_model_i.wr(acmd_host_model_i.uni(r.u, r.c),
        acmd_host_model_i.bip(r.b));
      settle();
      chk("regs", {pseudo_diff_o, bipolar_o}, {r.u, r.b});
      chk("com", 16'(common_ref_enable_o), 16'(r.c));
      chk("mode", 16'(mode_o), 16'(r.m));
      chk("twos", 16'(twos_comp_o), 16'(r.t));
      chk("chans", 16'({pos_ch_o, neg_ch_o}), 16'(chans(r)));
      $display("row %0d done", i);
    end
    // Scan coding: pairs 0/1 and 14/15 bipolar, channel 14 left out
    acmd_host_model_i.wr(acmd_host_model_i.uni(8'h00, 1'h0),
      acmd_host_model_i.bip(8'h81));
    scan = 16'h8007;
    settle();
    chk("scan", scan_twos_comp_o, 16'h8003);
    $display("scan test done");
    // Unknown select codes leave settings alone
    acmd_host_model_i.wr(16'ha7fc, 16'h0000);
    settle();
    chk("unk", {pseudo_diff_o, bipolar_o}, 16'h0081);
    $display("select test done");
    // Reset in mid-run clears everything
    reset_i = 1'h1;
    @(posedge mclk_i);
    #1;
    reset_i = 1'h0;
    chk("rst2", {pseudo_diff_o, bipolar_o}, 16'h0000);
    $display("mid reset test done");
    close_out();
  end
  // Watchdog well beyond the expected run
  initial begin
    #20000;
    errors++;
    close_out();
  end
endmodule // acmd_top_tb_top
`default_nettype wire
